// file: core/mms_defs.svh
// Offsets, field positions, reset values and timing for the mode sequencer
`ifndef MMS_DEFS_SVH
`define MMS_DEFS_SVH
// Register word indices; byte address is four times the index
`define MMS_IDX_CFG0     6'h00
`define MMS_IDX_CFG2     6'h02
`define MMS_IDX_CFG3     6'h03
`define MMS_IDX_CTRL     6'h04
`define MMS_IDX_STAT     6'h05
// Field positions
`define MMS_SINGLE_BIT   2
`define MMS_CYT_MSB      13
`define MMS_CYT_LSB      4
`define MMS_AVR_MSB      23
`define MMS_AVR_LSB      14
`define MMS_STR_MSB      13
`define MMS_STR_LSB      12
`define MMS_LEAD_MSB     19
`define MMS_LEAD_LSB     17
`define MMS_CONV_MSB     23
`define MMS_CONV_LSB     16
`define MMS_RUN_BIT      0
// Reset values
`define MMS_CFG_RST      32'h0000_0000
// Timing, in nanoseconds
`define MMS_CLK_NS       5
`define MMS_STEP_NS      2000
`define MMS_LP_NS        100000
`define MMS_SEQ_NS       6400000
`define MMS_PAIR2_NS     200000
`define MMS_PAIR3_NS     300000
`endif

// file: core/mms_pkg.sv
// Types shared by the measurement mode sequencer
`default_nettype none
package mms_pkg;
  typedef enum logic [6:0] {
    st_idle  = 7'h01,
    st_start = 7'h02,
    st_lead  = 7'h04,
    st_disch = 7'h08,
    st_pair  = 7'h10,
    st_gap   = 7'h20,
    st_sleep = 7'h40
  } mms_state_t;

  typedef struct packed {
    logic       single;
    logic [1:0] stretch;
    logic [2:0] lead;
    logic [9:0] cytime;
    logic [9:0] avrate;
    logic [7:0] conv_cnt;
  } mms_mode_t;
endpackage
`default_nettype wire

// file: core/mms_sequencer.sv
// Measurement mode sequencer with APB register access
//
// The implementer's own choices: the placing of the registers and the APB register port.
`include "mms_defs.svh"
`default_nettype none

module mms_sequencer
  import mms_pkg::*;
#(
  parameter int unsigned LP_TICK_CYC  = `MMS_LP_NS / `MMS_CLK_NS,
  parameter int unsigned SEQ_TICK_CYC = `MMS_SEQ_NS / `MMS_CLK_NS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        dis_done,
  output var  logic        dis_start,
  output var  logic        hs_osc_en,
  output var  logic        seq_done
);
  // ****************************************************************
  // Timing constants
  // ****************************************************************
  localparam int unsigned STEP_CYC = `MMS_STEP_NS / `MMS_CLK_NS;
  localparam int unsigned DIV_LIM [3] = '{STEP_CYC, LP_TICK_CYC,
                                          SEQ_TICK_CYC};
  localparam logic [9:0] PAIR2_TICKS = 10'(`MMS_PAIR2_NS / `MMS_LP_NS);
  localparam logic [9:0] PAIR3_TICKS = 10'(`MMS_PAIR3_NS / `MMS_LP_NS);
  // ****************************************************************
  // Rate dividers: 2 us step, 100 us low-power tick, period unit
  // ****************************************************************
  logic [2:0] tick;
  logic       tick_step;
  logic       tick_lp;
  logic       tick_seq;
  genvar g;
  for (g = 0; g < 3; g++) begin : g_div
    logic [20:0] cnt_reg;
    logic [20:0] cnt_next;
    // Free-running count with one-cycle wrap pulse
    always_comb begin
      cnt_next = (cnt_reg == 21'(DIV_LIM[g] - 1)) ? 21'h000000
                                                  : cnt_reg + 21'h000001;
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_reg <= 21'h000000;
      end else begin
        cnt_reg <= cnt_next;
      end
    end
    assign tick[g] = (cnt_reg == 21'(DIV_LIM[g] - 1));
  end
  assign tick_step = tick[0];
  assign tick_lp   = tick[1];
  assign tick_seq  = tick[2];
  // ****************************************************************
  // APB register file
  // ****************************************************************
  logic [31:0] cw0_reg, cw0_next;
  logic [31:0] cw2_reg, cw2_next;
  logic [31:0] cw3_reg, cw3_next;
  logic        run_reg, run_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  logic [31:0] stat_word;
  logic [5:0]  idx;
  logic        mapped;
  logic        setup_ph;
  logic        wr_acc;
  mms_state_t  state_reg, state_next;
  mms_mode_t   mode_reg, mode_next;
  mms_mode_t   live_mode;
  logic [15:0] seqn_reg, seqn_next;
  logic        osc_reg, osc_next;
  assign idx      = paddr[7:2];
  assign setup_ph = psel && !penable;
  assign wr_acc   = psel && penable && pready_reg && pwrite;
  assign mapped   = (idx == `MMS_IDX_CFG0) || (idx == `MMS_IDX_CFG2) ||
                    (idx == `MMS_IDX_CFG3) || (idx == `MMS_IDX_CTRL) ||
                    (idx == `MMS_IDX_STAT);
  assign stat_word = {seqn_reg, 5'h00, mode_reg.stretch, mode_reg.single,
                      osc_reg, state_reg};
  // Answer one cycle after setup; writes land at the access edge
  always_comb begin
    cw0_next     = cw0_reg;
    cw2_next     = cw2_reg;
    cw3_next     = cw3_reg;
    run_next     = run_reg;
    pready_next  = setup_ph;
    pslverr_next = setup_ph && !mapped;
    prdata_next  = prdata_reg;
    if (setup_ph) begin
      unique case (idx)
        `MMS_IDX_CFG0: prdata_next = cw0_reg;
        `MMS_IDX_CFG2: prdata_next = cw2_reg;
        `MMS_IDX_CFG3: prdata_next = cw3_reg;
        `MMS_IDX_CTRL: prdata_next = {31'h00000000, run_reg};
        `MMS_IDX_STAT: prdata_next = stat_word;
        default:       prdata_next = 32'h0000_0000;
      endcase
    end
    if (wr_acc) begin
      unique case (idx)
        `MMS_IDX_CFG0: cw0_next = pwdata;
        `MMS_IDX_CFG2: cw2_next = pwdata;
        `MMS_IDX_CFG3: cw3_next = pwdata;
        `MMS_IDX_CTRL: run_next = pwdata[`MMS_RUN_BIT];
        default:       run_next = run_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cw0_reg     <= `MMS_CFG_RST;
      cw2_reg     <= `MMS_CFG_RST;
      cw3_reg     <= `MMS_CFG_RST;
      run_reg     <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      cw0_reg     <= cw0_next;
      cw2_reg     <= cw2_next;
      cw3_reg     <= cw3_next;
      run_reg     <= run_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end
  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  // ****************************************************************
  // Mode fields as programmed
  // ****************************************************************
  assign live_mode = {cw2_reg[`MMS_SINGLE_BIT],
                      cw3_reg[`MMS_STR_MSB:`MMS_STR_LSB],
                      cw3_reg[`MMS_LEAD_MSB:`MMS_LEAD_LSB],
                      cw2_reg[`MMS_CYT_MSB:`MMS_CYT_LSB],
                      cw2_reg[`MMS_AVR_MSB:`MMS_AVR_LSB],
                      cw0_reg[`MMS_CONV_MSB:`MMS_CONV_LSB]};
  // ****************************************************************
  // Sequencer
  // ****************************************************************
  logic [10:0] dcnt_reg, dcnt_next;
  logic [9:0]  itv_reg, itv_next;
  logic [9:0]  wait_reg, wait_next;
  logic        start_reg, start_next;
  logic        done_reg, done_next;
  logic        stretched;
  logic        paired;
  logic        itv_tick;
  logic [10:0] total;
  logic        last;
  assign stretched = (mode_reg.stretch != 2'b00);
  assign paired    = mode_reg.stretch[1];
  assign itv_tick  = stretched ? tick_lp : tick_step;
  // Two discharges per ratio measurement; zero counts as one
  assign total = (mode_reg.avrate == 10'h000) ? 11'h002
                                              : {mode_reg.avrate, 1'b0};
  assign last  = (dcnt_reg == total);

  always_comb begin
    state_next = state_reg;
    mode_next  = mode_reg;
    dcnt_next  = dcnt_reg;
    wait_next  = wait_reg;
    osc_next   = osc_reg;
    seqn_next  = seqn_reg;
    start_next = 1'b0;
    done_next  = 1'b0;
    itv_next   = (itv_tick && itv_reg != 10'h3ff) ? itv_reg + 10'h001
                                                  : itv_reg;
    unique case (state_reg)
      st_idle: begin
        osc_next = 1'b0;
        if (run_reg) begin
          mode_next  = live_mode;
          dcnt_next  = 11'h000;
          state_next = st_start;
        end
      end
      // Start of one group: a single discharge or a half-bridge pair
      st_start: begin
        itv_next = 10'h000;
        osc_next = 1'b1;
        if (stretched && mode_reg.lead != 3'h0) begin
          wait_next  = {7'h00, mode_reg.lead};
          state_next = st_lead;
        end else begin
          start_next = 1'b1;
          state_next = st_disch;
        end
      end
      // Oscillator warm-up, or spacing inside a half bridge
      st_lead, st_pair: begin
        if (tick_lp) begin
          if (wait_reg <= 10'h001) begin
            start_next = 1'b1;
            state_next = st_disch;
          end else begin
            wait_next = wait_reg - 10'h001;
          end
        end
      end
      st_disch: begin
        if (dis_done) begin
          dcnt_next = dcnt_reg + 11'h001;
          if (paired && !dcnt_reg[0]) begin
            wait_next  = (mode_reg.stretch == 2'b10) ? PAIR2_TICKS
                                                     : PAIR3_TICKS;
            state_next = st_pair;
          end else begin
            if (stretched) begin
              osc_next = 1'b0;
            end
            state_next = st_gap;
            if (dcnt_next == total) begin
              done_next = 1'b1;
              seqn_next = seqn_reg + 16'h0001;
              if (mode_reg.single) begin
                osc_next   = 1'b0;
                wait_next  = {2'b00, mode_reg.conv_cnt};
                state_next = st_sleep;
              end
            end
          end
        end
      end
      // Interval from group start, in 2 us or 100 us units
      st_gap: begin
        if (itv_reg >= mode_reg.cytime) begin
          state_next = st_start;
          if (last) begin
            mode_next = live_mode;
            dcnt_next = 11'h000;
            if (!run_reg) begin
              state_next = st_idle;
            end
          end
        end
      end
      // Oscillator off for the sequence period
      st_sleep: begin
        osc_next = 1'b0;
        if (wait_reg == 10'h000) begin
          mode_next  = live_mode;
          dcnt_next  = 11'h000;
          state_next = run_reg ? st_start : st_idle;
        end else if (tick_seq) begin
          wait_next = wait_reg - 10'h001;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= st_idle;
      mode_reg  <= '0;
      dcnt_reg  <= 11'h000;
      itv_reg   <= 10'h000;
      wait_reg  <= 10'h000;
      osc_reg   <= 1'b0;
      seqn_reg  <= 16'h0000;
      start_reg <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      mode_reg  <= mode_next;
      dcnt_reg  <= dcnt_next;
      itv_reg   <= itv_next;
      wait_reg  <= wait_next;
      osc_reg   <= osc_next;
      seqn_reg  <= seqn_next;
      start_reg <= start_next;
      done_reg  <= done_next;
    end
  end
  assign dis_start = start_reg;
  assign hs_osc_en = osc_reg;
  assign seq_done  = done_reg;
  // ****************************************************************
  // Assertions and covers
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_cont_osc_on: assert property (
    (state_reg inside {st_disch, st_gap} && !mode_reg.single &&
     !stretched) |-> hs_osc_en)
    else $error("oscillator off in continuous mode");
  a_sleep_osc_off: assert property (
    state_reg == st_sleep |-> !hs_osc_en)
    else $error("oscillator on during sleep");
  a_stretch_gap_off: assert property (
    (state_reg == st_gap && stretched) |-> !hs_osc_en)
    else $error("oscillator on in stretched gap");
  a_disch_osc_run: assert property (
    dis_start |-> hs_osc_en ##1 (hs_osc_en throughout
                                 (state_reg == st_disch)[*1]))
    else $error("discharge without oscillator");
  a_pair_follow: assert property (
    (state_reg == st_disch && dis_done && paired && !dcnt_reg[0])
    |=> state_reg == st_pair && hs_osc_en)
    else $error("half bridge pair not kept together");
  a_pair_spacing: assert property (
    $rose(state_reg == st_pair) |-> wait_reg ==
      ((mode_reg.stretch == 2'b10) ? PAIR2_TICKS : PAIR3_TICKS))
    else $error("wrong pair spacing");
  a_gap_hold: assert property (
    (state_reg == st_gap && itv_reg < mode_reg.cytime)
    |=> state_reg == st_gap)
    else $error("gap ended before interval");
  a_lead_time: assert property (
    $rose(state_reg == st_lead) |-> wait_reg == 10'(mode_reg.lead)
      && hs_osc_en)
    else $error("wrong oscillator lead time");
  a_single_period: assert property (
    (seq_done && mode_reg.single) |-> state_reg == st_sleep &&
      wait_reg == 10'(mode_reg.conv_cnt))
    else $error("single sequence not followed by period");
  a_seq_length: assert property (
    seq_done |-> dcnt_reg == total && $past(state_reg) == st_disch)
    else $error("sequence length wrong");
  a_mode_steady: assert property (
    !$stable(mode_reg) |-> dcnt_reg == 11'h000)
    else $error("mode changed inside a sequence");
  c_cont_seq: cover property (seq_done && !mode_reg.single && !stretched);
  c_single_sleep: cover property (state_reg == st_sleep && tick_seq);
  c_pair: cover property (state_reg == st_pair ##1 dis_start);
  c_stretch_single: cover property (seq_done && mode_reg.single &&
                                    paired);
endmodule
`default_nettype wire

// file: verif/mms_front_model.sv
// Behavioural bridge front end answering each discharge start
`default_nettype none
module mms_front_model #(
  parameter int DLY = 10
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic dis_start,
  input  wire logic hs_osc_en,
  output var  logic dis_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cnt;
  logic busy;
  // Discharge lasts DLY cycles; lost if the oscillator stops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy     <= 1'b0;
      cnt      <= 0;
      dis_done <= 1'b0;
    end else begin
      dis_done <= 1'b0;
      if (dis_start) begin
        busy <= 1'b1;
        cnt  <= DLY;
      end else if (busy && !hs_osc_en) begin
        busy <= 1'b0;  // No clock, so no comparator edge
      end else if (busy && cnt == 1) begin
        busy     <= 1'b0;
        dis_done <= 1'b1;
      end else if (busy) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/test_measurement_mode_sequencer.sv
// Self-checking bench for the measurement mode sequencer
`include "mms_defs.svh"
`default_nettype none
module test_measurement_mode_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LP = 20, SQ = 50, DLY = 10, CY = 400;
  logic        pclk, presetn, psel, penable, pwrite;
  logic        pready, pslverr, dis_done, dis_start, hs_osc_en, seq_done;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  int          fail_count = 0, total_checks = 0, cyc = 0, t_rise = 0;
  int          lowc = 0, n_in = 0, seq_cnt = 0;
  logic        osc_q = 1'b0, fell = 1'b1;
  int          ts[$], ld[$], slen[$], lowrun[$];
  logic        lowb[$];

  mms_sequencer #(.LP_TICK_CYC(LP), .SEQ_TICK_CYC(SQ)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dis_done(dis_done),
    .dis_start(dis_start), .hs_osc_en(hs_osc_en), .seq_done(seq_done));
  mms_front_model #(.DLY(DLY)) front (.pclk(pclk), .presetn(presetn),
    .dis_start(dis_start), .hs_osc_en(hs_osc_en), .dis_done(dis_done));

  // Clock generator
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ********
  // Monitor: start times, oscillator gaps, sequence lengths
  // ********
  always @(negedge pclk) begin
    if (presetn) begin
      cyc++;
      if (hs_osc_en && !osc_q) begin
        lowrun.push_back(lowc);
        t_rise = cyc;
      end
      if (!hs_osc_en) lowc++;
      else lowc = 0;
      if (dis_start) begin
        ts.push_back(cyc);
        ld.push_back(cyc - t_rise);
        lowb.push_back(fell);
        fell = 1'b0;
        n_in++;
      end
      if (!hs_osc_en) fell = 1'b1;
      if (seq_done) begin
        slen.push_back(n_in);
        n_in = 0;
        seq_cnt++;
      end
      osc_q = hs_osc_en;
    end
  end

  // ********
  // Checking, bus and run tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rng(input string nm, input int v, lo, hi);
    chk(nm, 32'(v), (v >= lo && v <= hi) ? 32'(v) : 32'(lo));
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic tmo(input string nm);
    fail_count++;
    $display("CHECK FAILED %s expected answer seen timeout", nm);
    results();
  endtask

  task automatic apb(input logic w, input logic [5:0] ix,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    int n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {ix, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1) tmo("pready");
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] ix, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, ix, d, r, e);
  endtask

  task automatic rdc(input string nm, input logic [5:0] ix,
                     input logic [31:0] exp, input logic eerr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, ix, 32'h0, r, e);
    chk(nm, r, exp);
    chk({nm, " err"}, {31'h0, e}, {31'h0, eerr});
  endtask

  function automatic logic [31:0] c2f(input logic s, input int cy, av);
    return (32'(s) << `MMS_SINGLE_BIT) | (32'(cy) << `MMS_CYT_LSB)
         | (32'(av) << `MMS_AVR_LSB);
  endfunction

  task automatic go(input logic [31:0] c0, c2, c3);
    wr(`MMS_IDX_CFG0, c0);
    wr(`MMS_IDX_CFG2, c2);
    wr(`MMS_IDX_CFG3, c3);
    ts.delete(); ld.delete(); slen.delete(); lowrun.delete();
    lowb.delete();
    seq_cnt = 0;
    n_in = 0;
    wr(`MMS_IDX_CTRL, 32'h1);
  endtask

  task automatic fin(input int nseq);
    logic [31:0] r;
    logic        e;
    int          n = 0;
    while (seq_cnt < nseq && n < 40000) begin
      @(posedge pclk);
      n++;
    end
    if (seq_cnt < nseq) tmo("seq_done");
    wr(`MMS_IDX_CTRL, 32'h0);
    n = 0;
    do begin
      apb(1'b0, `MMS_IDX_STAT, 32'h0, r, e);
      n++;
    end while (r[6:0] !== 7'h01 && n < 600);
    if (r[6:0] !== 7'h01) tmo("idle");
  endtask

  // ********
  // Main sequence
  // ********
  initial begin : main
    int n, sp, ld_n, sg, gi;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, read-only status, unmapped word, field storage
    rdc("cfg0 rst", `MMS_IDX_CFG0, `MMS_CFG_RST, 1'b0);
    rdc("cfg2 rst", `MMS_IDX_CFG2, `MMS_CFG_RST, 1'b0);
    rdc("cfg3 rst", `MMS_IDX_CFG3, `MMS_CFG_RST, 1'b0);
    rdc("ctrl rst", `MMS_IDX_CTRL, 32'h0, 1'b0);
    rdc("unmapped", 6'h10, 32'h0, 1'b1);
    wr(`MMS_IDX_STAT, 32'hffff_ffff);
    rdc("stat", `MMS_IDX_STAT, 32'h1, 1'b0);
    wr(`MMS_IDX_CFG2, 32'h00ff_fff4);
    rdc("cfg2", `MMS_IDX_CFG2, 32'h00ff_fff4, 1'b0);
    wr(`MMS_IDX_CFG3, 32'h000e_3000);
    rdc("cfg3", `MMS_IDX_CFG3, 32'h000e_3000, 1'b0);
    wr(`MMS_IDX_CFG0, 32'h00ff_0000);
    rdc("cfg0", `MMS_IDX_CFG0, 32'h00ff_0000, 1'b0);
    $display("registers test done");
    // Continuous mode, sequence size changed mid-sequence
    go(32'h0, c2f(0, 2, 2), 32'h0);
    n = 0;
    while (ts.size() < 1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (ts.size() < 1) tmo("dis_start");
    wr(`MMS_IDX_CFG2, c2f(0, 2, 1));
    fin(2);
    chk("seq len 1", 32'(slen[0]), 32'd4);
    chk("seq len 2", 32'(slen[1]), 32'd2);
    for (int i = 1; i < 6; i++)
      chk("osc on", {31'h0, lowb[i]}, 0);
    for (int i = 1; i < 4; i++)
      rng("cycle gap", ts[i] - ts[i-1], CY, 2*CY+DLY+8);
    $display("continuous test done");
    // Single conversion mode with a two-unit sleep
    go(32'h0002_0000, c2f(1, 1, 1), 32'h0);
    fin(2);
    chk("single len", 32'(slen[0]), 32'd2);
    chk("single osc", {31'h0, lowb[1]}, 0);
    rng("single sleep", lowrun[1], SQ, 2*SQ+8);
    $display("single test done");
    // Stretched modes: spread 1, 2, 3 with lead, stretched single
    for (int k = 0; k < 4; k++) begin
      sp = (k == 0) ? 1 : (k == 2) ? 3 : 2;
      ld_n = (k == 2) ? 2 : 0;
      sg = (k == 3) ? 1 : 0;
      go(sg ? 32'h0002_0000 : 32'h0, c2f(sg[0], 8, 2),
         32'((sp << 12) | (ld_n << 17)));
      fin(1 + sg);
      gi = (sp == 1) ? 1 : 2;  // Spread one: each discharge is a group
      rng("group gap", ts[gi] - ts[0], 6*LP, 9*LP+4);
      chk("osc off between", {31'h0, lowb[2]}, 1);
      if (sp == 1) begin
        chk("osc off single", {31'h0, lowb[1]}, 1);
        rng("single gap", ts[2] - ts[1], 6*LP, 9*LP+4);
      end else begin
        chk("osc pair a", {31'h0, lowb[1]}, 0);
        chk("osc pair b", {31'h0, lowb[3]}, 0);
        rng("pair gap", ts[1] - ts[0], (sp-1)*LP, sp*LP+DLY+4);
      end
      if (ld_n == 0) rng("no lead", ld[0], 0, 1);
      else rng("lead", ld[0], (ld_n-1)*LP, ld_n*LP+4);
      if (sg) rng("str sleep", lowrun[2], SQ, 2*SQ+DLY+8);
      $display("stretched test %0d done", k);
    end
    results();
  end
endmodule
`default_nettype wire
